//--- core/dts_params.svh
// constants for the delay trigger sequencer
// assumes a 200 MHz system clock; included by the package, the core and the bench
//
// Summary of operation
// - seven selectable trigger modes
// - internal rate from 100 uHz to 10 MHz
// - external edges start cycles per mode
// - external single shot takes one edge only
// - enter re-arms single shot, fires trigger in manual
// - line mode triggers from power line
// - time zero until holdoff or tail end
// - pairs run from first to second delay
// - cycle active from trigger until delays done
// - trigger during cycle ignored, overrun flashes
// - inhibit or editing blocks trigger, flashes
// - burst lamp lit while burst value nonzero
// - fast sources tamed by holdoff or prescaler
// - repeated trigger display key cycles its parameters
// - edge keys move edge, lamps show it
// - typed digits take effect on units key
// - up and down step value by step
// - cursor keys scale step by ten
// - step key toggles step view and lamp
// - step view: entry sets, up/down scale
// - prescaler passes every Nth trigger
`ifndef DTS_PARAMS_SVH
`define DTS_PARAMS_SVH
`define DTS_VW 48
`define DTS_NPAR 16
`define DTS_CLK_NS 5
`define DTS_TAIL_NS 25
`define DTS_TAIL_CYC ((`DTS_TAIL_NS + `DTS_CLK_NS - 1) / `DTS_CLK_NS)
`define DTS_RATE_MAX_HZ 10000000
`define DTS_RATE_MIN_CYC (1000000000 / (`DTS_CLK_NS * `DTS_RATE_MAX_HZ))
`define DTS_FLASH_MS 100
`define DTS_FLASH_CYC (`DTS_FLASH_MS * 1000000 / `DTS_CLK_NS)
`define DTS_RST_RATE 48'h0000_0000_4E20
`define DTS_RST_STEP 48'h0000_0000_0001
`define DTS_PAR_RATE 4'h8
`define DTS_PAR_PRESC 4'hA
`define DTS_PAR_HOLD 4'h9
`define DTS_PAR_BURST 4'hB
`define DTS_PAR_LEVEL 4'hC
`define DTS_CUR_MAX 4'hE
`define DTS_TRIG_SUBS 2'h2
`define DTS_A_STATUS 8'h00
`define DTS_A_DISP 8'h04
`define DTS_A_VAL_LO 8'h08
`define DTS_A_VAL_HI 8'h0C
`define DTS_A_KEY 8'h10
`define DTS_A_ENTRY 8'h14
`define DTS_K_UNITS 5'h0A
`define DTS_K_UP 5'h0B
`define DTS_K_DOWN 5'h0C
`define DTS_K_CUR_L 5'h0D
`define DTS_K_CUR_R 5'h0E
`define DTS_K_EDGE_L 5'h0F
`define DTS_K_EDGE_R 5'h10
`define DTS_K_STEP 5'h11
`define DTS_K_ENTER 5'h12
`define DTS_K_DISP 5'h13
`define DTS_K_MODE_UP 5'h14
`define DTS_K_MODE_DN 5'h15
`define DTS_K_CANCEL 5'h16
`endif

//--- core/dts_pkg.sv
// types of the delay trigger sequencer
// assumes the constants header for widths
`include "dts_params.svh"
package dts_pkg;
    typedef enum logic [2:0] {
        MODE_INT,
        MODE_EXT_RISE,
        MODE_EXT_FALL,
        MODE_SGL_RISE,
        MODE_SGL_FALL,
        MODE_MANUAL,
        MODE_LINE
    } dts_mode_t;

    typedef enum logic [1:0] {
        DISP_TRIG,
        DISP_BURST,
        DISP_DELAY,
        DISP_LEVEL
    } dts_disp_t;

    typedef struct packed {
        dts_mode_t mode;
        dts_disp_t disp;
        logic [1:0] sub;
        logic [2:0] edge_sel;
        logic step_view;
        logic [3:0] cursor;
        logic entering;
        logic [`DTS_VW-1:0] acc;
        logic [`DTS_NPAR-1:0][`DTS_VW-1:0] val;
        logic [`DTS_NPAR-1:0][`DTS_VW-1:0] step;
        logic armed;
        logic [`DTS_VW-1:0] rate_cnt;
        logic [`DTS_VW-1:0] presc_cnt;
        logic running;
        logic [`DTS_VW-1:0] cnt;
        logic [2:0] ext_sync;
        logic [2:0] line_sync;
        logic [1:0] inh_sync;
        logic [31:0] ovr_cnt;
        logic [31:0] blk_cnt;
        logic t0;
        logic active;
        logic [3:0] pair;
        logic ovr_ind;
        logic blk_ind;
        logic burst_ind;
        logic step_lamp;
        logic [7:0] edge_lamp;
        logic [31:0] rdata;
    } dts_state_t;
endpackage : dts_pkg

//--- core/dts_core.sv
// delay trigger sequencer: trigger selection, delay cycle and keypad logic
// assumes key events arrive as writes to the key register; pins are async
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "dts_params.svh"
module dts_core #(
    parameter logic [31:0] FLASH_CYCLES = `DTS_FLASH_CYC
) (
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire logic OUTSIDE_TRIGGER_INPUT_I,
    input wire logic LINE_REF_I,
    input wire logic INHIBIT_I,
    output logic ZERO_TIME_OUTPUT_O,
    output logic FIRST_PAIR_OUTPUT_O,
    output logic SECOND_PAIR_OUTPUT_O,
    output logic THIRD_PAIR_OUTPUT_O,
    output logic FOURTH_PAIR_OUTPUT_O,
    output logic CYCLE_ACTIVE_INDICATOR_O,
    output logic BLOCKED_TRIGGER_INDICATOR_O,
    output logic OVERRUN_INDICATOR_O,
    output logic BURST_INDICATOR_O,
    output logic STEP_LAMP_O,
    output logic [7:0] EDGE_LAMPS_O
);

    dts_pkg::dts_state_t s_q;
    dts_pkg::dts_state_t s_d;

    function automatic logic [`DTS_VW-1:0] pow10(input logic [3:0] e);
        logic [`DTS_VW-1:0] r;
        r = `DTS_RST_STEP;
        for (int i = 0; i < 15; i++) begin
            if (4'(i) < e) begin
                r = `DTS_VW'(r * `DTS_VW'(10));
            end
        end
        return r;
    endfunction : pow10

    ////////////////////////////////////////////////////////////////////////
    // derived values
    logic [3:0] sel;
    logic [`DTS_VW-1:0] max_dly;
    logic [`DTS_VW-1:0] cyc_end;
    logic [`DTS_VW-1:0] tail_end;
    logic [`DTS_VW-1:0] period;
    logic [`DTS_VW-1:0] presc_n;
    logic [2*`DTS_VW-1:0] prod;

    always_comb begin
        case (s_q.disp)
            dts_pkg::DISP_DELAY: sel = {1'b0, s_q.edge_sel};
            dts_pkg::DISP_LEVEL: sel = `DTS_PAR_LEVEL + {2'h0, s_q.edge_sel[2:1]};
            dts_pkg::DISP_BURST: sel = `DTS_PAR_BURST;
            default: sel = `DTS_PAR_RATE + {2'h0, s_q.sub};
        endcase
    end

    always_comb begin
        max_dly = '0;
        for (int i = 0; i < 8; i++) begin
            if (s_q.val[i] > max_dly) begin
                max_dly = s_q.val[i];
            end
        end
        tail_end = max_dly + `DTS_VW'(`DTS_TAIL_CYC);
        // later of holdoff and tail after the longest delay
        cyc_end = (s_q.val[`DTS_PAR_HOLD] > tail_end) ? s_q.val[`DTS_PAR_HOLD] : tail_end;
        // period clamped to the fastest rate
        period = (s_q.val[`DTS_PAR_RATE] < `DTS_VW'(`DTS_RATE_MIN_CYC)) ?
            `DTS_VW'(`DTS_RATE_MIN_CYC) : s_q.val[`DTS_PAR_RATE];
        presc_n = (s_q.val[`DTS_PAR_PRESC] == '0) ? `DTS_RST_STEP : s_q.val[`DTS_PAR_PRESC];
        prod = s_q.acc * pow10(WDATA_I[11:8]);
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    logic key;
    logic [4:0] kc;
    logic rise;
    logic fall;
    logic raw_trig;
    logic man_trig;
    logic trig;
    logic [`DTS_VW-1:0] nxt;

    always_comb begin
        s_d = s_q;
        kc = WDATA_I[4:0];
        key = WR_I && (ADDR_I == `DTS_A_KEY);
        man_trig = 1'b0;
        nxt = '0;

        // pin synchronisers
        s_d.ext_sync = {s_q.ext_sync[1:0], OUTSIDE_TRIGGER_INPUT_I};
        s_d.line_sync = {s_q.line_sync[1:0], LINE_REF_I};
        s_d.inh_sync = {s_q.inh_sync[0], INHIBIT_I};
        rise = s_q.ext_sync[1] && !s_q.ext_sync[2];
        fall = !s_q.ext_sync[1] && s_q.ext_sync[2];

        // keypad
        if (key) begin
            if (kc < `DTS_K_UNITS) begin
                s_d.acc = `DTS_VW'(s_q.acc * `DTS_VW'(10) + `DTS_VW'(kc));
                s_d.entering = 1'b1;
            end else if (kc == `DTS_K_UNITS) begin
                if (s_q.entering) begin
                    if (s_q.step_view) begin
                        s_d.step[sel] = prod[`DTS_VW-1:0];
                    end else begin
                        s_d.val[sel] = prod[`DTS_VW-1:0];
                    end
                end
                s_d.acc = '0;
                s_d.entering = 1'b0;
            end else if (kc == `DTS_K_CANCEL) begin
                s_d.acc = '0;
                s_d.entering = 1'b0;
            end else if (kc == `DTS_K_UP) begin
                if (s_q.step_view) begin
                    s_d.step[sel] = `DTS_VW'(s_q.step[sel] * `DTS_VW'(10));
                end else begin
                    s_d.val[sel] = s_q.val[sel] + s_q.step[sel];
                end
            end else if (kc == `DTS_K_DOWN) begin
                if (s_q.step_view) begin
                    if (s_q.step[sel] >= `DTS_VW'(10)) begin
                        s_d.step[sel] = s_q.step[sel] / `DTS_VW'(10);
                    end
                end else if (s_q.val[sel] >= s_q.step[sel]) begin
                    s_d.val[sel] = s_q.val[sel] - s_q.step[sel];
                end else begin
                    s_d.val[sel] = '0;
                end
            end else if (kc == `DTS_K_CUR_L) begin
                if (s_q.cursor < `DTS_CUR_MAX) begin
                    s_d.step[sel] = `DTS_VW'(s_q.step[sel] * `DTS_VW'(10));
                    s_d.cursor = s_q.cursor + 4'h1;
                end
            end else if (kc == `DTS_K_CUR_R) begin
                if (s_q.cursor != 4'h0) begin
                    s_d.step[sel] = s_q.step[sel] / `DTS_VW'(10);
                    s_d.cursor = s_q.cursor - 4'h1;
                end
            end else if (kc == `DTS_K_EDGE_L) begin
                if (s_q.disp == dts_pkg::DISP_DELAY || s_q.disp == dts_pkg::DISP_LEVEL) begin
                    s_d.edge_sel = s_q.edge_sel - 3'h1;
                end
            end else if (kc == `DTS_K_EDGE_R) begin
                if (s_q.disp == dts_pkg::DISP_DELAY || s_q.disp == dts_pkg::DISP_LEVEL) begin
                    s_d.edge_sel = s_q.edge_sel + 3'h1;
                end
            end else if (kc == `DTS_K_STEP) begin
                s_d.step_view = !s_q.step_view;
            end else if (kc == `DTS_K_ENTER) begin
                if (s_q.mode == dts_pkg::MODE_MANUAL) begin
                    man_trig = 1'b1;
                end else if (s_q.mode == dts_pkg::MODE_SGL_RISE ||
                             s_q.mode == dts_pkg::MODE_SGL_FALL) begin
                    s_d.armed = 1'b1;
                end
            end else if (kc == `DTS_K_DISP) begin
                if (dts_pkg::dts_disp_t'(WDATA_I[9:8]) == s_q.disp) begin
                    if (s_q.disp == dts_pkg::DISP_TRIG && s_q.sub != `DTS_TRIG_SUBS) begin
                        s_d.sub = s_q.sub + 2'h1;
                    end else begin
                        s_d.sub = 2'h0;
                    end
                end else begin
                    s_d.disp = dts_pkg::dts_disp_t'(WDATA_I[9:8]);
                    s_d.sub = 2'h0;
                end
                s_d.step_view = 1'b0;
            end else if (kc == `DTS_K_MODE_UP || kc == `DTS_K_MODE_DN) begin
                if (kc == `DTS_K_MODE_UP) begin
                    s_d.mode = (s_q.mode == dts_pkg::MODE_LINE) ? dts_pkg::MODE_INT :
                        dts_pkg::dts_mode_t'(s_q.mode + 3'h1);
                end else begin
                    s_d.mode = (s_q.mode == dts_pkg::MODE_INT) ? dts_pkg::MODE_LINE :
                        dts_pkg::dts_mode_t'(s_q.mode - 3'h1);
                end
                s_d.armed = 1'b1;
                s_d.rate_cnt = '0;
            end
        end

        // trigger sources
        raw_trig = 1'b0;
        s_d.rate_cnt = (s_q.mode == dts_pkg::MODE_INT) ? s_q.rate_cnt + `DTS_VW'(1) : '0;
        case (s_q.mode)
            dts_pkg::MODE_INT: begin
                if (s_q.rate_cnt >= period - `DTS_VW'(1)) begin
                    raw_trig = 1'b1;
                    s_d.rate_cnt = '0;
                end
            end
            dts_pkg::MODE_EXT_RISE: raw_trig = rise;
            dts_pkg::MODE_EXT_FALL: raw_trig = fall;
            dts_pkg::MODE_SGL_RISE: raw_trig = rise && s_q.armed;
            dts_pkg::MODE_SGL_FALL: raw_trig = fall && s_q.armed;
            dts_pkg::MODE_MANUAL: raw_trig = man_trig;
            default: raw_trig = s_q.line_sync[1] && !s_q.line_sync[2];
        endcase
        if (raw_trig && (s_q.mode == dts_pkg::MODE_SGL_RISE ||
                         s_q.mode == dts_pkg::MODE_SGL_FALL)) begin
            s_d.armed = 1'b0;
        end

        // prescaler passes every nth trigger
        trig = 1'b0;
        if (raw_trig) begin
            if (s_q.presc_cnt + `DTS_VW'(1) >= presc_n) begin
                trig = 1'b1;
                s_d.presc_cnt = '0;
            end else begin
                s_d.presc_cnt = s_q.presc_cnt + `DTS_VW'(1);
            end
        end

        // flash stretchers count down
        s_d.ovr_cnt = (s_q.ovr_cnt != 32'h0) ? s_q.ovr_cnt - 32'h1 : 32'h0;
        s_d.blk_cnt = (s_q.blk_cnt != 32'h0) ? s_q.blk_cnt - 32'h1 : 32'h0;

        // delay cycle
        if (s_q.running) begin
            nxt = s_q.cnt + `DTS_VW'(1);
            s_d.cnt = nxt;
            if (nxt >= cyc_end) begin
                s_d.running = 1'b0;
            end
        end
        if (trig) begin
            if (s_q.inh_sync[1] || s_q.entering) begin
                s_d.blk_cnt = FLASH_CYCLES;
            end else if (s_q.running) begin
                s_d.ovr_cnt = FLASH_CYCLES;
            end else begin
                s_d.running = 1'b1;
                s_d.cnt = '0;
            end
        end

        // registered outputs
        s_d.t0 = s_d.running;
        s_d.active = s_d.running && (s_d.cnt <= max_dly);
        for (int k = 0; k < 4; k++) begin
            s_d.pair[k] = s_d.running && (s_d.cnt >= s_q.val[2*k]) &&
                (s_d.cnt < s_q.val[2*k+1]);
        end
        s_d.ovr_ind = s_d.ovr_cnt != 32'h0;
        s_d.blk_ind = s_d.blk_cnt != 32'h0;
        s_d.burst_ind = s_d.val[`DTS_PAR_BURST] != '0;
        s_d.step_lamp = s_d.step_view;
        s_d.edge_lamp = 8'h01 << s_d.edge_sel;

        // register reads
        s_d.rdata = 32'h0;
        if (RD_I) begin
            if (ADDR_I == `DTS_A_STATUS) begin
                s_d.rdata = {16'h0, s_q.pair, s_q.blk_ind, s_q.ovr_ind, s_q.active,
                    s_q.t0, s_q.running, s_q.armed, s_q.entering, 2'h0, s_q.mode};
            end else if (ADDR_I == `DTS_A_DISP) begin
                s_d.rdata = {16'h0, s_q.cursor, s_q.step_view, s_q.edge_sel,
                    2'h0, s_q.sub, 2'h0, s_q.disp};
            end else if (ADDR_I == `DTS_A_VAL_LO) begin
                s_d.rdata = s_q.step_view ? s_q.step[sel][31:0] : s_q.val[sel][31:0];
            end else if (ADDR_I == `DTS_A_VAL_HI) begin
                s_d.rdata = {16'h0, s_q.step_view ? s_q.step[sel][47:32] :
                    s_q.val[sel][47:32]};
            end else if (ADDR_I == `DTS_A_ENTRY) begin
                s_d.rdata = s_q.acc[31:0];
            end else begin
                s_d.rdata = 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            s_q <= '0;
            s_q.mode <= dts_pkg::MODE_INT;
            s_q.disp <= dts_pkg::DISP_TRIG;
            s_q.val[`DTS_PAR_RATE] <= `DTS_RST_RATE;
            s_q.step <= {`DTS_NPAR{`DTS_RST_STEP}};
            s_q.edge_lamp <= 8'h01;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign RDATA_O = s_q.rdata;
    assign ZERO_TIME_OUTPUT_O = s_q.t0;
    assign FIRST_PAIR_OUTPUT_O = s_q.pair[0];
    assign SECOND_PAIR_OUTPUT_O = s_q.pair[1];
    assign THIRD_PAIR_OUTPUT_O = s_q.pair[2];
    assign FOURTH_PAIR_OUTPUT_O = s_q.pair[3];
    assign CYCLE_ACTIVE_INDICATOR_O = s_q.active;
    assign BLOCKED_TRIGGER_INDICATOR_O = s_q.blk_ind;
    assign OVERRUN_INDICATOR_O = s_q.ovr_ind;
    assign BURST_INDICATOR_O = s_q.burst_ind;
    assign STEP_LAMP_O = s_q.step_lamp;
    assign EDGE_LAMPS_O = s_q.edge_lamp;

endmodule : dts_core

//--- testbench/dts_core_assertions.sv
// concurrent checks on the delay trigger sequencer top ports
// assumes binding onto dts_core with its flash length handed on
`timescale 1ns/1ps
module dts_chk #(
    parameter logic [31:0] FLASH_CYCLES = 32'h0000_0008
) (
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic INHIBIT_I,
    input wire logic ZERO_TIME_OUTPUT_O,
    input wire logic FIRST_PAIR_OUTPUT_O,
    input wire logic SECOND_PAIR_OUTPUT_O,
    input wire logic THIRD_PAIR_OUTPUT_O,
    input wire logic FOURTH_PAIR_OUTPUT_O,
    input wire logic CYCLE_ACTIVE_INDICATOR_O,
    input wire logic BLOCKED_TRIGGER_INDICATOR_O,
    input wire logic OVERRUN_INDICATOR_O,
    input wire logic BURST_INDICATOR_O,
    input wire logic STEP_LAMP_O,
    input wire logic [7:0] EDGE_LAMPS_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);
    logic pairs;
    logic [31:0] ovr_run_q;
    logic [31:0] blk_run_q;
    assign pairs = FIRST_PAIR_OUTPUT_O | SECOND_PAIR_OUTPUT_O | THIRD_PAIR_OUTPUT_O
        | FOURTH_PAIR_OUTPUT_O;
    ////////////////////////////////////////
    // length of the current flash of each indicator
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ovr_run_q <= 32'h0;
            blk_run_q <= 32'h0;
        end else begin
            ovr_run_q <= OVERRUN_INDICATOR_O ? ovr_run_q + 32'h1 : 32'h0;
            blk_run_q <= BLOCKED_TRIGGER_INDICATOR_O ? blk_run_q + 32'h1 : 32'h0;
        end
    end
    ////////////////////////////////////////
    a_pair_in_t0: assert property (pairs |-> ZERO_TIME_OUTPUT_O)
        else $error("pair output high outside time zero");
    a_active_in_t0: assert property (CYCLE_ACTIVE_INDICATOR_O |-> ZERO_TIME_OUTPUT_O)
        else $error("cycle active without time zero");
    a_t0_with_active: assert property ($rose(ZERO_TIME_OUTPUT_O) |-> CYCLE_ACTIVE_INDICATOR_O)
        else $error("time zero rose without cycle active");
    a_t0_tail_gap: assert property ($fell(ZERO_TIME_OUTPUT_O) |-> !$past(CYCLE_ACTIVE_INDICATOR_O, 4))
        else $error("time zero fell too soon after last delay");
    a_overrun_cause: assert property ($rose(OVERRUN_INDICATOR_O) |-> $past(ZERO_TIME_OUTPUT_O))
        else $error("overrun flashed with no cycle running");
    a_overrun_len: assert property ($fell(OVERRUN_INDICATOR_O) |-> ovr_run_q >= FLASH_CYCLES)
        else $error("overrun flash too short");
    a_blocked_len: assert property ($fell(BLOCKED_TRIGGER_INDICATOR_O) |-> blk_run_q >= FLASH_CYCLES)
        else $error("blocked flash too short");
    a_inhibit_blocks: assert property (INHIBIT_I [*6] |-> !$rose(ZERO_TIME_OUTPUT_O))
        else $error("cycle started while inhibited");
    a_burst_cause: assert property (!$stable(BURST_INDICATOR_O) |-> $past(WR_I) || $past(WR_I, 2)
        || $past(WR_I, 3))
        else $error("burst lamp changed without a key");
    a_step_cause: assert property (!$stable(STEP_LAMP_O) |-> $past(WR_I) || $past(WR_I, 2)
        || $past(WR_I, 3))
        else $error("step lamp changed without a key");
    a_edge_onehot: assert property ($onehot(EDGE_LAMPS_O))
        else $error("edge lamps not one-hot");
    a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("read data outside its cycle");
    c_overrun: cover property ($rose(OVERRUN_INDICATOR_O));
    c_blocked: cover property ($rose(BLOCKED_TRIGGER_INDICATOR_O));
    c_pair: cover property ($rose(FIRST_PAIR_OUTPUT_O));
endmodule : dts_chk
bind dts_core dts_chk #(.FLASH_CYCLES(FLASH_CYCLES)) dts_chk_inst (.*);

//--- testbench/dts_trig_src.sv
// outside trigger source and power-line reference model
// assumes the bench clock; every change lands right after a rising edge
`timescale 1ns/1ps
module dts_trig_src (
    input wire logic clk_i,
    output logic ext_o,
    output logic line_o
);
    initial begin
        ext_o = 1'b0;
        line_o = 1'b0;
    end
    ////////////////////////////////////////
    // one rise and one fall; hold picks a prompt or a slow source
    task automatic pulse(input int hold, input bit on_line);
        @(posedge clk_i);
        if (on_line)
            line_o <= 1'b1;
        else
            ext_o <= 1'b1;
        repeat (hold) @(posedge clk_i);
        line_o <= 1'b0;
        ext_o <= 1'b0;
        repeat (hold) @(posedge clk_i);
    endtask : pulse
endmodule : dts_trig_src

//--- testbench/dts_core_test.sv
// self-checking bench for the delay trigger sequencer
// assumes the trigger source model and the bound checker
`timescale 1ns/1ps
`include "dts_params.svh"
module dts_core_test;
    logic sys_clk;
    logic nrst;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic outside_trigger_input;
    logic line_ref;
    logic inhibit;
    logic t0;
    logic [3:0] pair;
    logic active;
    logic blocked;
    logic overrun;
    logic burst;
    logic step_lamp;
    logic [7:0] edge_lamps;
    integer seed = 32'h4EB7;
    int failures = 0;
    int num_checks = 0;
    logic [31:0] rq[$];
    logic [23:0] cq[$];
    logic rd_d = 1'b0;
    logic [7:0] t0w = 8'h00;
    logic [7:0] pd = 8'h00;
    logic [7:0] pw = 8'h00;
    logic ovr_seen = 1'b0;
    logic blk_seen = 1'b0;
    logic oth_seen = 1'b0;
    // time zero width, first pair delay and width, in cycles
    localparam logic [23:0] CYC = {8'h19, 8'h05, 8'h0F};
    dts_core #(.FLASH_CYCLES(32'h0000_0008)) dts_core_inst (
        .SYS_CLK_I(sys_clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .OUTSIDE_TRIGGER_INPUT_I(outside_trigger_input),
        .LINE_REF_I(line_ref), .INHIBIT_I(inhibit), .ZERO_TIME_OUTPUT_O(t0),
        .FIRST_PAIR_OUTPUT_O(pair[0]), .SECOND_PAIR_OUTPUT_O(pair[1]),
        .THIRD_PAIR_OUTPUT_O(pair[2]), .FOURTH_PAIR_OUTPUT_O(pair[3]),
        .CYCLE_ACTIVE_INDICATOR_O(active), .BLOCKED_TRIGGER_INDICATOR_O(blocked),
        .OVERRUN_INDICATOR_O(overrun), .BURST_INDICATOR_O(burst),
        .STEP_LAMP_O(step_lamp), .EDGE_LAMPS_O(edge_lamps));
    dts_trig_src dts_trig_src_inst (.clk_i(sys_clk), .ext_o(outside_trigger_input), .line_o(line_ref));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        rq.push_back(exp);
    endtask : rd_reg
    task automatic key(input logic [4:0] k, input logic [3:0] x);
        wr_reg(`DTS_A_KEY, {20'h0_0000, x, 3'h0, k});
    endtask : key
    task automatic hit(input bit on_line);
        dts_trig_src_inst.pulse(30 + ($random(seed) & 15), on_line);
    endtask : hit
    task automatic settle(input int tail);
        for (int i = 0; i < 400 && cq.size() > 0; i++) @(posedge sys_clk);
        repeat (tail) @(posedge sys_clk);
        chk(cq.size(), 32'h0);
    endtask : settle
    ////////////////////////////////////////
    // watches read data and measures every delay cycle
    always @(posedge sys_clk) begin
        if (rd_d)
            chk(rdata, rq.pop_front());
        rd_d = rd;
        if (blocked === 1'b1)
            blk_seen = 1'b1;
        if (overrun === 1'b1)
            ovr_seen = 1'b1;
        if (nrst === 1'b1 && pair[3:1] !== 3'h0)
            oth_seen = 1'b1;
        if (t0 === 1'b1) begin
            t0w++;
            if (pair[0] === 1'b1)
                pw++;
            else if (pw == 8'h00)
                pd++;
        end else if (t0w != 8'h00) begin
            chk({t0w, pd, pw}, cq.size() ? {8'h00, cq.pop_front()} : 32'hFFFF_FFFF);
            t0w = 8'h00;
            pd = 8'h00;
            pw = 8'h00;
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        summarize();
    end
    initial begin
        nrst = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        inhibit = 1'b0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        rd_reg(`DTS_A_VAL_LO, 32'h0000_4E20);
        rd_reg(8'h20, 32'h0);
        chk(edge_lamps, 8'h01);
        key(`DTS_K_DISP, 4'h2);
        key(5'h05, 4'h0);
        rd_reg(`DTS_A_VAL_LO, 32'h0);
        key(`DTS_K_UNITS, 4'h0);
        rd_reg(`DTS_A_VAL_LO, 32'h5);
        key(`DTS_K_EDGE_R, 4'h0);
        repeat (2) @(posedge sys_clk);
        chk(edge_lamps, 8'h02);
        key(5'h09, 4'h0);
        key(`DTS_K_UNITS, 4'h0);
        key(`DTS_K_UP, 4'h0);
        key(`DTS_K_CUR_L, 4'h0);
        key(`DTS_K_UP, 4'h0);
        rd_reg(`DTS_A_VAL_LO, 32'h14);
        key(`DTS_K_STEP, 4'h0);
        repeat (2) @(posedge sys_clk);
        chk(step_lamp, 1'b1);
        rd_reg(`DTS_A_VAL_LO, 32'hA);
        key(`DTS_K_UP, 4'h0);
        rd_reg(`DTS_A_VAL_LO, 32'h64);
        key(5'h03, 4'h0);
        key(`DTS_K_UNITS, 4'h0);
        rd_reg(`DTS_A_VAL_LO, 32'h3);
        key(`DTS_K_STEP, 4'h0);
        repeat (2) @(posedge sys_clk);
        chk(step_lamp, 1'b0);
        key(`DTS_K_DOWN, 4'h0);
        rd_reg(`DTS_A_VAL_LO, 32'h11);
        key(`DTS_K_UP, 4'h0);
        key(`DTS_K_EDGE_L, 4'h0);
        repeat (2) @(posedge sys_clk);
        chk(edge_lamps, 8'h01);
        for (int m = 0; m < 2; m++) begin
            key(`DTS_K_MODE_UP, 4'h0);
            cq.push_back(CYC);
            hit(1'b0);
            settle(10);
        end
        for (int m = 0; m < 2; m++) begin
            key(`DTS_K_MODE_UP, 4'h0);
            cq.push_back(CYC);
            hit(1'b0);
            hit(1'b0);
            settle(10);
            key(`DTS_K_ENTER, 4'h0);
            cq.push_back(CYC);
            hit(1'b0);
            settle(10);
        end
        key(`DTS_K_MODE_UP, 4'h0);
        cq.push_back(CYC);
        key(`DTS_K_ENTER, 4'h0);
        settle(10);
        key(`DTS_K_MODE_UP, 4'h0);
        cq.push_back(CYC);
        hit(1'b1);
        settle(10);
        key(`DTS_K_DISP, 4'h0);
        key(5'h04, 4'h0);
        key(`DTS_K_UNITS, 4'h1);
        rd_reg(`DTS_A_VAL_LO, 32'h28);
        key(`DTS_K_MODE_UP, 4'h0);
        repeat (3) cq.push_back(CYC);
        settle(0);
        key(`DTS_K_MODE_DN, 4'h0);
        for (int m = 0; m < 5; m++) key(`DTS_K_MODE_DN, 4'h0);
        settle(60);
        cq.push_back(CYC);
        dts_trig_src_inst.pulse(4, 1'b0);
        dts_trig_src_inst.pulse(4, 1'b0);
        settle(10);
        chk(ovr_seen, 1'b1);
        inhibit <= 1'b1;
        hit(1'b0);
        settle(10);
        chk(blk_seen, 1'b1);
        inhibit <= 1'b0;
        repeat (2) key(`DTS_K_DISP, 4'h0);
        key(5'h02, 4'h0);
        key(`DTS_K_UNITS, 4'h0);
        rd_reg(`DTS_A_VAL_LO, 32'h2);
        cq.push_back(CYC);
        hit(1'b0);
        hit(1'b0);
        settle(10);
        repeat (2) key(`DTS_K_DISP, 4'h0);
        key(5'h04, 4'h0);
        key(`DTS_K_UNITS, 4'h1);
        cq.push_back({8'h28, 8'h05, 8'h0F});
        hit(1'b0);
        hit(1'b0);
        settle(10);
        key(`DTS_K_DISP, 4'h1);
        key(5'h01, 4'h0);
        key(`DTS_K_UNITS, 4'h0);
        repeat (3) @(posedge sys_clk);
        chk(burst, 1'b1);
        chk(oth_seen, 1'b0);
        summarize();
    end
endmodule : dts_core_test
